/* verilog/psbcd_pkg.sv */
// shared widths, reset values, pin bundles and states of the command decode
package psbcd_pkg;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int PSBCD_ADDR_W = 23;
   localparam int PSBCD_DATA_W = 16;
   localparam int PSBCD_LANES = 2;
   localparam int PSBCD_LANE_W = 8;
   localparam longint PSBCD_ARRAY_BITS = 64'd134217728;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic PSBCD_RST_SYNC_MODE = 1'b0;
   localparam logic PSBCD_RST_WR_LEVEL = 1'b0;
   localparam logic [PSBCD_DATA_W-1:0] PSBCD_RST_DATA = 16'h0000;
   localparam logic [PSBCD_ADDR_W-1:0] PSBCD_RST_ADDR = 23'h000000;
   localparam logic [PSBCD_LANES-1:0] PSBCD_LANES_NONE = 2'h0;

   // ---------------------------------------------------------------
   // pin bundles
   // ---------------------------------------------------------------
   typedef struct packed {
      logic chip_select_n;
      logic power_select;
      logic addr_valid_n;
      logic write_n;
      logic output_n;
      logic low_byte_sel_n;
      logic high_byte_sel_n;
      logic burst_clk;
      logic [PSBCD_ADDR_W-1:0] word_address;
      logic [PSBCD_DATA_W-1:0] data_in;
   } psbcd_pins_in_type;

   typedef struct packed {
      logic [PSBCD_DATA_W-1:0] data_out;
      logic [PSBCD_LANES-1:0] data_oe;
      logic wait_out;
      logic wait_oe;
   } psbcd_pins_out_type;

   typedef struct packed {
      logic load;
      logic sync_mode;
      logic wr_level;
   } psbcd_cfg_type;

   typedef enum logic [2:0] {
      PS_STANDBY,
      PS_ASYNC,
      PS_BURST_RD,
      PS_BURST_WR,
      PS_POWER_DOWN
   } psbcd_state_type;

endpackage : psbcd_pkg

/* verilog/psbcd_array.sv */
// word storage with per-lane write enables and combinational read
`timescale 1ns/1ns
module psbcd_array import psbcd_pkg::*; #(
   parameter int ADDR_W = PSBCD_ADDR_W
) (
   // clock
   input wire logic clock,
   input wire logic ce,
   // write side
   input wire logic wr_en,
   input wire logic [PSBCD_LANES-1:0] wr_lanes,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [PSBCD_DATA_W-1:0] wr_data,
   // read side
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [PSBCD_DATA_W-1:0] rd_data
);

   localparam int WORDS = 1 << ADDR_W;

   // contents are not reset: a memory array holds no defined value
   logic [PSBCD_DATA_W-1:0] mem_q [WORDS];

   always_ff @(posedge clock) begin
      if (ce && wr_en) begin
         for (int l = 0; l < PSBCD_LANES; l++) begin
            if (wr_lanes[l]) begin
               mem_q[wr_addr][l*PSBCD_LANE_W +: PSBCD_LANE_W] <=
                  wr_data[l*PSBCD_LANE_W +: PSBCD_LANE_W];
            end
         end
      end
   end

   assign rd_data = mem_q[rd_addr];

endmodule : psbcd_array

/* verilog/psbcd_decode.sv */
// pin-level command decode of a 16-bit pseudo-static memory
`timescale 1ns/1ns
// How it works
// - array of 134,217,728 bits as 16-bit words, 23-bit word address
// - asynchronous random or synchronous burst access, chosen by config
// - selected only when chip select low and power select high
// - power select low gives power down, all outputs released
// - byte selects gate lanes on read and write; none means no access
// - async read: write strobe high, output strobe low; write reversed
// - async address passes while valid strobe low, held after its rise
// - burst start address taken on clock edge with valid strobe low
// - single-pulse mode decides write at latch, no write suspend
// - burst read advances and drives selected lanes each clock edge
// - output strobe high suspends burst read, data released, wait held
// - burst write advances each clock, lanes per cycle, level suspend
// - wait driven high during burst write
// - data bus at latch: lanes per selects, input ignored, else released
// - chip select high ends a burst and releases data and wait
// - after reset the mode is asynchronous until reconfigured
module psbcd_decode import psbcd_pkg::*; #(
   parameter int ADDR_W = PSBCD_ADDR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // memory pins
   input wire psbcd_pins_in_type pins_in,
   output psbcd_pins_out_type pins_out,
   // configuration
   input wire psbcd_cfg_type cfg,
   // state seen from outside
   output logic sync_mode_q,
   output logic wr_level_q
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > PSBCD_ADDR_W) begin : gen_bad_addr_w
      $error("psbcd_decode: ADDR_W out of range");
   end

   // ---------------------------------------------------------------
   // decode of the pin levels
   // ---------------------------------------------------------------
   function automatic logic [PSBCD_LANES-1:0] lane_sel(
      input logic low_n,
      input logic high_n
   );
      lane_sel = {~high_n, ~low_n};
   endfunction : lane_sel

   psbcd_state_type state_q;
   logic bclk_q;
   logic [ADDR_W-1:0] lat_addr_q;
   logic [ADDR_W-1:0] burst_addr_q;
   logic cs_wr_q;
   logic prev_sel_q;
   psbcd_pins_out_type out_q;
   logic [PSBCD_DATA_W-1:0] rd_data;

   logic selected;
   logic [PSBCD_LANES-1:0] lanes;
   logic any_lane;
   logic clk_edge;
   logic [ADDR_W-1:0] async_addr;
   logic async_rd;
   logic async_wr;
   logic burst_latch;
   logic adv_rd;
   logic adv_wr;
   logic wr_en;
   logic [ADDR_W-1:0] acc_addr;

   assign selected = pins_in.power_select & ~pins_in.chip_select_n;
   assign lanes = lane_sel(pins_in.low_byte_sel_n, pins_in.high_byte_sel_n);
   assign any_lane = lanes != PSBCD_LANES_NONE;
   // burst clock is a sampled pin; its rise is the valid edge
   assign clk_edge = pins_in.burst_clk & ~bclk_q;

   assign async_addr = pins_in.addr_valid_n ? lat_addr_q
                       : pins_in.word_address[ADDR_W-1:0];

   // output strobe low in a write only when selection began that way
   assign async_rd = selected & ~sync_mode_q & pins_in.write_n
                     & ~pins_in.output_n & any_lane;
   assign async_wr = selected & ~sync_mode_q & ~pins_in.write_n
                     & (pins_in.output_n | cs_wr_q) & any_lane;

   assign burst_latch = selected & sync_mode_q & clk_edge
                        & ~pins_in.addr_valid_n;
   assign adv_rd = selected & (state_q == PS_BURST_RD) & clk_edge
                   & pins_in.addr_valid_n & ~pins_in.output_n;
   // single-pulse mode ignores the strobe once the write is decided
   assign adv_wr = selected & (state_q == PS_BURST_WR) & clk_edge
                   & pins_in.addr_valid_n
                   & (~wr_level_q | ~pins_in.write_n);

   assign wr_en = async_wr | (adv_wr & any_lane);
   assign acc_addr = sync_mode_q ? burst_addr_q : async_addr;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   psbcd_array #(
      .ADDR_W(ADDR_W)
   ) u_array (
      .clock(clock),
      .ce(ce),
      .wr_en(wr_en),
      .wr_lanes(lanes),
      .wr_addr(acc_addr),
      .wr_data(pins_in.data_in),
      .rd_addr(acc_addr),
      .rd_data(rd_data)
   );

   // ---------------------------------------------------------------
   // configuration
   // ---------------------------------------------------------------
   // mode loads only in standby, which includes the cycle a burst is latched in, so the mode can move as a burst starts
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_mode_q <= PSBCD_RST_SYNC_MODE;
         wr_level_q <= PSBCD_RST_WR_LEVEL;
      end else if (ce && cfg.load && state_q == PS_STANDBY) begin
         sync_mode_q <= cfg.sync_mode;
         wr_level_q <= cfg.wr_level;
      end
   end

   // ---------------------------------------------------------------
   // operating state
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= PS_STANDBY;
      end else if (ce) begin
         if (!pins_in.power_select) begin
            // power down only from standby; an access is dropped first
            if (state_q == PS_STANDBY || state_q == PS_POWER_DOWN) begin
               state_q <= PS_POWER_DOWN;
            end else begin
               state_q <= PS_STANDBY;
            end
         end else if (pins_in.chip_select_n) begin
            state_q <= PS_STANDBY;
         end else if (!sync_mode_q) begin
            state_q <= PS_ASYNC;
         end else if (burst_latch) begin
            state_q <= pins_in.write_n ? PS_BURST_RD : PS_BURST_WR;
         end
      end
   end

   // ---------------------------------------------------------------
   // address capture
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lat_addr_q <= PSBCD_RST_ADDR[ADDR_W-1:0];
      end else if (ce && !pins_in.addr_valid_n) begin
         // tracks while low, so the value at the strobe rise stays
         lat_addr_q <= pins_in.word_address[ADDR_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         burst_addr_q <= PSBCD_RST_ADDR[ADDR_W-1:0];
      end else if (ce) begin
         if (burst_latch) begin
            burst_addr_q <= pins_in.word_address[ADDR_W-1:0];
         end else if (adv_rd || adv_wr) begin
            burst_addr_q <= burst_addr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bclk_q <= 1'b0;
         prev_sel_q <= 1'b0;
         cs_wr_q <= 1'b0;
      end else if (ce) begin
         bclk_q <= pins_in.burst_clk;
         prev_sel_q <= selected;
         if (!selected) begin
            cs_wr_q <= 1'b0;
         end else if (!prev_sel_q) begin
            cs_wr_q <= ~pins_in.write_n & ~pins_in.output_n;
         end
      end
   end

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_q.data_out <= PSBCD_RST_DATA;
         out_q.data_oe <= PSBCD_LANES_NONE;
         out_q.wait_out <= 1'b0;
         out_q.wait_oe <= 1'b0;
      end else if (ce) begin
         if (!selected) begin
            out_q.data_oe <= PSBCD_LANES_NONE;
            out_q.wait_oe <= 1'b0;
         end else if (!sync_mode_q) begin
            out_q.wait_oe <= 1'b0;
            out_q.data_out <= rd_data;
            out_q.data_oe <= async_rd ? lanes : PSBCD_LANES_NONE;
         end else if (burst_latch) begin
            out_q.wait_out <= 1'b0;
            out_q.wait_oe <= 1'b1;
            // contents invalid here; input ignored with write strobe low
            out_q.data_oe <= (~pins_in.output_n & pins_in.write_n)
                             ? lanes : PSBCD_LANES_NONE;
         end else begin
            unique case (state_q)
               PS_BURST_RD: begin
                  if (pins_in.output_n) begin
                     out_q.data_oe <= PSBCD_LANES_NONE;
                  end else if (adv_rd) begin
                     out_q.data_out <= rd_data;
                     out_q.data_oe <= lanes;
                     out_q.wait_out <= 1'b1;
                     out_q.wait_oe <= 1'b1;
                  end
               end
               PS_BURST_WR: begin
                  out_q.data_oe <= PSBCD_LANES_NONE;
                  out_q.wait_out <= 1'b1;
                  out_q.wait_oe <= 1'b1;
               end
               PS_STANDBY, PS_ASYNC, PS_POWER_DOWN: begin
                  out_q.data_oe <= PSBCD_LANES_NONE;
                  out_q.wait_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   assign pins_out = out_q;

endmodule : psbcd_decode

/* tb/psbcd_checker.sv */
// port assertions for the command decode
`timescale 1ns/1ns
module psbcd_checker import psbcd_pkg::*; #(
   parameter int ADDR_W = PSBCD_ADDR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // pins and mode
   input wire psbcd_pins_in_type pins_in,
   input wire psbcd_pins_out_type pins_out,
   input wire psbcd_cfg_type cfg,
   input wire logic sync_mode_q,
   input wire logic wr_level_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic clk_prev_q;
   logic sel;
   logic rise;
   logic [1:0] ln_n;
   // frozen with the design while ce is low, so both see the same edge
   always_ff @(posedge clock) begin
      if (ce) begin
         clk_prev_q <= pins_in.burst_clk;
      end
   end
   assign sel = !pins_in.chip_select_n && pins_in.power_select;
   assign rise = ce && sel && pins_in.burst_clk && !clk_prev_q;
   assign ln_n = {pins_in.high_byte_sel_n, pins_in.low_byte_sel_n};
   pd_release_a: assert property (
      ce && !pins_in.power_select |=> pins_out.data_oe == 2'h0
      && !pins_out.wait_oe) else $error("drive in power down");
   desel_release_a: assert property (
      ce && pins_in.chip_select_n |=> pins_out.data_oe == 2'h0
      && !pins_out.wait_oe) else $error("drive while deselected");
   async_wait_a: assert property (
      ce && !sync_mode_q |=> !pins_out.wait_oe)
      else $error("wait driven in async mode");
   async_read_a: assert property (
      ce && !sync_mode_q && sel && pins_in.write_n && !pins_in.output_n
      |=> pins_out.data_oe == ~$past(ln_n)) else $error("async lanes");
   no_lane_a: assert property (
      ce && sel && ln_n == 2'h3 |=> pins_out.data_oe == 2'h0)
      else $error("lane driven with none selected");
   burst_wr_a: assert property (
      sync_mode_q && rise && !pins_in.addr_valid_n && !pins_in.write_n
      ##1 (ce && sel)[*2] ##1 (rise && pins_in.addr_valid_n) |=>
      pins_out.wait_oe && pins_out.wait_out && pins_out.data_oe == 2'h0)
      else $error("burst write outputs");
   burst_rd_a: assert property (
      sync_mode_q && rise && !pins_in.addr_valid_n && pins_in.write_n
      ##1 (ce && sel)[*2] ##1 (rise && pins_in.addr_valid_n
      && !pins_in.output_n) |=> pins_out.wait_oe && pins_out.wait_out
      && pins_out.data_oe == ~$past(ln_n)) else $error("burst read outputs");
   suspend_hold_a: assert property (
      ce && sync_mode_q && sel && pins_in.output_n && pins_in.addr_valid_n
      && pins_out.wait_oe && pins_out.wait_out |=> pins_out.wait_oe
      && pins_out.wait_out && pins_out.data_oe == 2'h0)
      else $error("suspend outputs");
   latch_bus_a: assert property (
      ce && sync_mode_q && rise && !pins_in.addr_valid_n |=>
      pins_out.wait_oe && pins_out.data_oe ==
      ((!$past(pins_in.output_n) && $past(pins_in.write_n))
      ? ~$past(ln_n) : 2'h0)) else $error("latch cycle outputs");
endmodule : psbcd_checker

bind psbcd_decode psbcd_checker #(.ADDR_W(ADDR_W)) psbcd_checker_i (
   .clock(clock), .rst_n(rst_n), .ce(ce), .pins_in(pins_in),
   .pins_out(pins_out), .cfg(cfg), .sync_mode_q(sync_mode_q),
   .wr_level_q(wr_level_q));

/* tb/psbcd_host.sv */
// host controller model that drives the device pins
`timescale 1ns/1ns
module psbcd_host import psbcd_pkg::*; (
   // clock
   input wire logic clock,
   // toward the device
   output psbcd_pins_in_type pins_in,
   output psbcd_cfg_type cfg
);
   initial begin
      pins_in = '1;
      pins_in.burst_clk = 1'b0;
      cfg = '0;
   end
   // c = {power, cs_n, adv_n, we_n, oe_n, burst clock}
   task automatic cyc(input logic [5:0] c, input logic [1:0] l,
      input logic [22:0] a, input logic [15:0] d);
      @(negedge clock);
      {pins_in.power_select, pins_in.chip_select_n, pins_in.addr_valid_n,
       pins_in.write_n, pins_in.output_n, pins_in.burst_clk} = c;
      {pins_in.high_byte_sel_n, pins_in.low_byte_sel_n} = l;
      pins_in.word_address = a;
      // a released bus never keeps its last value
      pins_in.data_in = (c[1] && !c[4]) ? d : ~pins_in.data_in;
   endtask : cyc
   // burst clock stays low outside bursts; returns once outputs settle
   task automatic bedge(input logic [3:0] c, input logic [1:0] l,
      input logic [22:0] a, input logic [15:0] d);
      cyc({1'b1, c, 1'b0}, l, a, d);
      cyc({1'b1, c, 1'b1}, l, a, d);
      @(negedge clock);
   endtask : bedge
   task automatic setup(input logic sync, input logic lvl);
      repeat (2) cyc(6'b110110, 2'h3, 23'h0, 16'h0);
      cfg = '{load: 1'b1, sync_mode: sync, wr_level: lvl};
      @(negedge clock);
      cfg.load = 1'b0;
   endtask : setup
endmodule : psbcd_host

/* tb/testbench.sv */
// self-checking bench: reference memory against the command decode
`timescale 1ns/1ns
module testbench;
   import psbcd_pkg::*;
   localparam logic [5:0] IDLE = 6'b110110;
   localparam logic [5:0] WR = 6'b100010;
   localparam logic [5:0] RD = 6'b100100;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   psbcd_pins_in_type pins_in;
   psbcd_pins_out_type pins_out;
   psbcd_cfg_type cfg;
   logic sync_mode_q;
   logic wr_level_q;
   logic [15:0] mem [64];
   int err_count = 0;
   int total_checks = 0;
   int a;
   always #5 clock = ~clock;
   psbcd_decode #(.ADDR_W(6)) psbcd_decode_i (.clock(clock), .rst_n(rst_n),
      .ce(ce), .pins_in(pins_in), .pins_out(pins_out), .cfg(cfg),
      .sync_mode_q(sync_mode_q), .wr_level_q(wr_level_q));
   psbcd_host psbcd_host_i (.clock(clock), .pins_in(pins_in), .cfg(cfg));
   function automatic logic [15:0] mk(input logic [1:0] l);
      return {{8{~l[1]}}, {8{~l[0]}}};
   endfunction : mk
   // wait level only counts while driven
   function automatic logic [3:0] ctl();
      return {pins_out.data_oe, pins_out.wait_oe,
         pins_out.wait_oe & pins_out.wait_out};
   endfunction : ctl
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_ctl(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_ctl
   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic aw(input int ad, input logic [1:0] l, input logic [15:0] v);
      psbcd_host_i.cyc(WR, l, 23'(ad), v);
      psbcd_host_i.cyc(IDLE, l, 23'(ad), v);
      mem[ad] = (mem[ad] & ~mk(l)) | (v & mk(l));
   endtask : aw
   task automatic ar(input int ad, input logic [1:0] l);
      repeat (2) psbcd_host_i.cyc(RD, l, 23'(ad), 16'h0);
      chk_ctl(ctl(), {~l, 2'h0});
      chk_word(pins_out.data_out & mk(l), mem[ad] & mk(l));
      psbcd_host_i.cyc(IDLE, l, 23'(ad), 16'h0);
   endtask : ar
   task automatic term();
      repeat (2) psbcd_host_i.cyc(IDLE, 2'h3, 23'h0, 16'h0);
      chk_ctl(ctl(), 4'h0);
   endtask : term
   // level mode suspends every other cycle; pulse mode ignores write_n
   task automatic bw(input int ad, input logic lvl);
      logic [1:0] l;
      logic [15:0] v;
      logic sus;
      psbcd_host_i.bedge(4'b0001, 2'h0, 23'(ad), 16'h0);
      chk_ctl(ctl(), 4'h2);
      for (int i = 0; i < 8; i++) begin
         l = 2'($urandom);
         v = 16'($urandom);
         sus = lvl && i[0];
         psbcd_host_i.bedge({2'b01, sus | !lvl, 1'b1}, l, 23'($urandom), v);
         chk_ctl(ctl(), 4'h3);
         if (!sus) begin
            mem[ad] = (mem[ad] & ~mk(l)) | (v & mk(l));
            ad++;
         end
      end
      term();
   endtask : bw
   // oe_n low at latch shows the selected lanes in the latch cycle
   task automatic br(input int ad, input logic oe_n);
      logic [1:0] l;
      l = 2'($urandom);
      psbcd_host_i.bedge({3'b001, oe_n}, l, 23'(ad), 16'h0);
      chk_ctl(ctl(), {oe_n ? 2'h0 : ~l, 2'h2});
      for (int i = 0; i < 8; i++) begin
         psbcd_host_i.bedge(i == 4 ? 4'b0111 : 4'b0110, l, 23'($urandom),
            16'h0);
         if (i == 4) begin
            chk_ctl(ctl(), 4'h3);
         end else begin
            chk_ctl(ctl(), {~l, 2'h3});
            chk_word(pins_out.data_out & mk(l), mem[ad] & mk(l));
            ad++;
         end
      end
      term();
   endtask : br
   initial begin
      repeat (100000) @(posedge clock);
      err_count++;
      conclude();
   end
   initial begin
      void'($urandom(55));
      repeat (12) @(negedge clock);
      chk_ctl(ctl(), 4'h0);
      chk_word({14'h0, sync_mode_q, wr_level_q}, 16'h0);
      rst_n = 1'b1;
      for (a = 0; a < 64; a++) aw(a, 2'h0, 16'($urandom));
      repeat (40) aw($urandom % 64, 2'($urandom), 16'($urandom));
      ar(5, 2'h3);
      repeat (40) ar($urandom % 64, 2'($urandom));
      psbcd_host_i.cyc(RD, 2'h0, 23'h9, 16'h0);
      repeat (2) psbcd_host_i.cyc(6'b101100, 2'h0, 23'h21, 16'h0);
      chk_word(pins_out.data_out, mem[9]);
      // ce low must hold the last read on the pins
      psbcd_host_i.cyc(RD, 2'h0, 23'h3, 16'h0);
      psbcd_host_i.cyc(IDLE, 2'h0, 23'h3, 16'h0);
      ce = 1'b0;
      psbcd_host_i.cyc(IDLE, 2'h0, 23'h3, 16'h0);
      chk_ctl(ctl(), 4'hc);
      chk_word(pins_out.data_out, mem[3]);
      ce = 1'b1;
      term();
      repeat (2) psbcd_host_i.cyc(6'b000100, 2'h0, 23'h9, 16'h0);
      chk_ctl(ctl(), 4'h0);
      psbcd_host_i.setup(1'b1, 1'b0);
      chk_word({14'h0, sync_mode_q, wr_level_q}, 16'h2);
      a = $urandom % 56;
      bw(a, 1'b0);
      br(a, 1'b1);
      psbcd_host_i.setup(1'b1, 1'b1);
      chk_word({14'h0, sync_mode_q, wr_level_q}, 16'h3);
      bw(a, 1'b1);
      br(a, 1'b0);
      // reset in mid-burst falls back to the asynchronous default
      psbcd_host_i.bedge(4'b0011, 2'h0, 23'h0, 16'h0);
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      chk_ctl(ctl(), 4'h0);
      chk_word({14'h0, sync_mode_q, wr_level_q}, 16'h0);
      rst_n = 1'b1;
      psbcd_host_i.setup(1'b0, 1'b0);
      ar(a, 2'h0);
      conclude();
   end
endmodule : testbench
